// >>> src/flash_port_defines.svh
// Register offsets, reset values, command codes and timing counts of the flash update port
`ifndef FLASH_PORT_DEFINES_SVH
`define FLASH_PORT_DEFINES_SVH
`define OFS_CHIP_CONTROL      8'h9F
`define OFS_TIMED_ACCESS      8'hC0
`define OFS_TRIGGER           8'hA4
`define OFS_UPDATE_PERMISSION 8'hA5
`define OFS_ADDR_LOW          8'hA6
`define OFS_ADDR_HIGH         8'hA7
`define OFS_DATA_BYTE         8'hAE
`define OFS_COMMAND           8'hAF
`define RST_BYTE_ZERO         8'h00
`define RST_COMMAND           8'h30
`define TA_FIRST              8'hAA
`define TA_SECOND             8'h55
`define CMD_PAGE_ERASE_AP     8'h22
`define CMD_BYTE_PROGRAM_AP   8'h21
`define CMD_BYTE_READ_AP      8'h00
`define BIT_GO                0
`define BIT_SELF_PROG_ENABLE  0
`define BIT_BOOT_SELECT       1
`define BIT_FAULT             6
`define BIT_APP_UPDATE        0
`define UPDATE_PERM_MASK      8'h1F
`define FLASH_BYTES           17'h04000
`define FLASH_ADDR_W          14
`define PAGE_BYTES            128
`define PAGE_SHIFT            7
`define ERASE_TICKS           16'h0040
`define PROGRAM_TICKS         16'h0008
`endif

// >>> src/flash_port_pkg.sv
// Types shared by the flash update port modules
package flash_port_pkg;
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } sfr_req_t;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10,
    OP_WAIT  = 2'b11
  } op_state_t;

  typedef enum logic [1:0] {
    TA_LOCKED = 2'b00,
    TA_HALF   = 2'b01,
    TA_OPEN   = 2'b10
  } ta_state_t;
endpackage : flash_port_pkg

// >>> src/timed_access_unlock.sv
// Timed-access sequence detector guarding protected registers
`timescale 1ns/1ps
`include "flash_port_defines.svh"
module timed_access_unlock (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire flash_port_pkg::sfr_req_t  req,
  output logic                           unlocked
);
  flash_port_pkg::ta_state_t stateReg;
  flash_port_pkg::ta_state_t stateNext;

  // Any write other than the exact pair closes the window, so one unlock opens one write only
  always_comb
  begin
    stateNext = stateReg;
    if (req.wrEn)
    begin
      if (req.addr == `OFS_TIMED_ACCESS && req.wrData == `TA_FIRST)
        stateNext = flash_port_pkg::TA_HALF;
      else if (req.addr == `OFS_TIMED_ACCESS && req.wrData == `TA_SECOND && stateReg == flash_port_pkg::TA_HALF)
        stateNext = flash_port_pkg::TA_OPEN;
      else
        stateNext = flash_port_pkg::TA_LOCKED;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      stateReg <= flash_port_pkg::TA_LOCKED;
    else
      stateReg <= stateNext;
  end

  assign unlocked = (stateReg == flash_port_pkg::TA_OPEN);

  AST_TA_ONE_SHOT: assert property (@(posedge clk) disable iff (rst)
    (unlocked && req.wrEn) |=> !unlocked)
    else $error("Unlock window survived a write");
endmodule : timed_access_unlock

// >>> src/flash_array.sv
// Flash byte array with port read, code-fetch read, byte program and page erase
`timescale 1ns/1ps
`include "flash_port_defines.svh"
module flash_array (
  input  wire logic                       clk,
  input  wire logic [`FLASH_ADDR_W-1:0]   portAddr,
  output logic      [7:0]                 portData,
  input  wire logic                       programEn,
  input  wire logic [7:0]                 programData,
  input  wire logic                       eraseEn,
  input  wire logic [`FLASH_ADDR_W-1:0]   codeAddr,
  output logic      [7:0]                 codeData
);
  logic [7:0] mem [0:`FLASH_BYTES-1];
  logic [`FLASH_ADDR_W-`PAGE_SHIFT-1:0] pageIdx;

  assign pageIdx = portAddr[`FLASH_ADDR_W-1:`PAGE_SHIFT];

  // Erase clears the whole aligned page, whatever the low address bits say
  always_ff @(posedge clk)
  begin
    if (eraseEn)
    begin
      for (int i = 0; i < `PAGE_BYTES; i++)
        mem[{pageIdx, i[`PAGE_SHIFT-1:0]}] <= 8'hFF;
    end
    else if (programEn)
      mem[portAddr] <= programData;
    portData <= mem[portAddr];
    codeData <= mem[codeAddr];
  end
endmodule : flash_array

// >>> src/in_app_flash_update_port.sv
// Top of the in-application flash update port: registers, sequencer, stall and fault logic
`timescale 1ns/1ps
`include "flash_port_defines.svh"
// Summary of operation
// - Low address register, read and write, gives flash address bits 7 to 0.
// - After a read, the fetched flash byte is left in the data register.
// - Writing 1 to go bit starts the operation and stalls the core.
// - Stall is released when the operation ends; execution continues afterwards.
// - Go bit clears itself and always reads back as zero.
// - Trigger write accepted only right after the 0AAh, 55h timed-access pair.
// - With self-program enable cleared, triggers are ignored.
// - Erase and program need the RC oscillator; disabling stops it under external clock.
// - Self-program enable writes take effect only after the unlock pair.
// - The security lock does not block read, program or erase.
// - Command 22h is page erase, 21h is byte program of the application area.
// - Page erase clears a whole aligned 128-byte page.
// - Every flash byte is readable through the code-read path.
// - High address register, read and write, gives flash address bits 15 to 8.
// - A bad trigger sets the fault flag; software clears it.
// - Setting self-program enable turns the RC oscillator on.
// - Without app-area update permission, erase and program are refused.
module in_app_flash_update_port (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire flash_port_pkg::sfr_req_t   sfrReq,
  output logic      [7:0]                 sfrRdData,
  output logic                            cpuStall,
  output logic                            rcOscEnable,
  input  wire logic                       extClkSelect,
  input  wire logic                       rcTick,
  input  wire logic                       brownOutInhibit,
  input  wire logic                       securityLock,
  input  wire logic [`FLASH_ADDR_W-1:0]   codeAddr,
  output logic      [7:0]                 codeData
);
  localparam int READ_RELEASE_MAX = 2;

  // Pin-side inputs pass two flops; stage one feeds stage two only
  logic [2:0] pinMeta;
  logic [2:0] pinSync;
  logic       rcTickSeen;
  logic       rcTickEdge;
  logic       unlocked;
  logic [7:0] flashPortData;
  logic       programEn;
  logic       eraseEn;

  logic [7:0]                addrLowReg,    addrLowNext;
  logic [7:0]                addrHighReg,   addrHighNext;
  logic [7:0]                dataByteReg,   dataByteNext;
  logic [7:0]                commandReg,    commandNext;
  logic [7:0]                updPermReg,    updPermNext;
  logic                      enableReg,     enableNext;
  logic                      bootSelReg,    bootSelNext;
  logic                      faultReg,      faultNext;
  logic [7:0]                rdDataReg,     rdDataNext;
  flash_port_pkg::op_state_t stateReg,      stateNext;
  logic [15:0]               tickCountReg,  tickCountNext;
  logic [15:0]               tickLimitReg,  tickLimitNext;
  logic                      stallReg,      stallNext;
  logic                      oscReg,        oscNext;

  logic [15:0] opAddr;
  logic        isEraseCmd;
  logic        isProgramCmd;
  logic        isReadCmd;
  logic        goWrite;
  logic        goAccepted;
  logic        goFault;
  logic        protWrite;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pinMeta    <= 3'h0;
      pinSync    <= 3'h0;
      rcTickSeen <= 1'b0;
    end
    else
    begin
      pinMeta    <= {brownOutInhibit, extClkSelect, rcTick};
      pinSync    <= pinMeta;
      rcTickSeen <= pinSync[0];
    end
  end

  assign rcTickEdge = pinSync[0] & ~rcTickSeen;

  timed_access_unlock u_unlock (
    .clk      (clk),
    .rst      (rst),
    .req      (sfrReq),
    .unlocked (unlocked)
  );

  flash_array u_array (
    .clk         (clk),
    .portAddr    (opAddr[`FLASH_ADDR_W-1:0]),
    .portData    (flashPortData),
    .programEn   (programEn),
    .programData (dataByteReg),
    .eraseEn     (eraseEn),
    .codeAddr    (codeAddr),
    .codeData    (codeData)
  );

  assign opAddr       = {addrHighReg, addrLowReg};
  assign isEraseCmd   = (commandReg == `CMD_PAGE_ERASE_AP);
  assign isProgramCmd = (commandReg == `CMD_BYTE_PROGRAM_AP);
  assign isReadCmd    = (commandReg == `CMD_BYTE_READ_AP);
  assign protWrite    = sfrReq.wrEn & unlocked;
  // The security lock input is deliberately not a term here: locked parts still self-program
  assign goWrite      = protWrite && sfrReq.addr == `OFS_TRIGGER && sfrReq.wrData[`BIT_GO]
                        && enableReg && stateReg == flash_port_pkg::OP_IDLE;
  assign goFault      = ({1'b0, opAddr} >= `FLASH_BYTES)
                        || !(isEraseCmd || isProgramCmd || isReadCmd)
                        || ((isEraseCmd || isProgramCmd) && !updPermReg[`BIT_APP_UPDATE])
                        || ((isEraseCmd || isProgramCmd) && pinSync[2]);
  assign goAccepted   = goWrite & ~goFault;
  assign eraseEn      = (stateReg == flash_port_pkg::OP_WRITE) & isEraseCmd;
  assign programEn    = (stateReg == flash_port_pkg::OP_WRITE) & isProgramCmd;

  // Register file writes
  always_comb
  begin
    addrLowNext  = addrLowReg;
    addrHighNext = addrHighReg;
    commandNext  = commandReg;
    updPermNext  = updPermReg;
    enableNext   = enableReg;
    bootSelNext  = bootSelReg;
    faultNext    = faultReg;
    dataByteNext = dataByteReg;
    if (sfrReq.wrEn)
    begin
      if (sfrReq.addr == `OFS_ADDR_LOW)
        addrLowNext = sfrReq.wrData;
      else if (sfrReq.addr == `OFS_ADDR_HIGH)
        addrHighNext = sfrReq.wrData;
      else if (sfrReq.addr == `OFS_COMMAND)
        commandNext = sfrReq.wrData;
      else if (sfrReq.addr == `OFS_DATA_BYTE)
        dataByteNext = sfrReq.wrData;
      else if (sfrReq.addr == `OFS_UPDATE_PERMISSION && unlocked)
        updPermNext = sfrReq.wrData & `UPDATE_PERM_MASK;
      else if (sfrReq.addr == `OFS_CHIP_CONTROL && unlocked)
      begin
        enableNext  = sfrReq.wrData[`BIT_SELF_PROG_ENABLE];
        bootSelNext = sfrReq.wrData[`BIT_BOOT_SELECT];
        faultNext   = sfrReq.wrData[`BIT_FAULT];
      end
    end
    // Hardware set of the fault flag beats a software clear in the same cycle
    if (goWrite && goFault)
      faultNext = 1'b1;
    if (stateReg == flash_port_pkg::OP_READ)
      dataByteNext = flashPortData;
  end

  // Sequencer; erase and program times are counted in RC ticks, not system clocks
  always_comb
  begin
    stateNext     = stateReg;
    tickCountNext = tickCountReg;
    tickLimitNext = tickLimitReg;
    case (stateReg)
      flash_port_pkg::OP_IDLE:
      begin
        if (goAccepted)
        begin
          tickCountNext = 16'h0000;
          tickLimitNext = isEraseCmd ? `ERASE_TICKS : `PROGRAM_TICKS;
          stateNext     = isReadCmd ? flash_port_pkg::OP_READ : flash_port_pkg::OP_WRITE;
        end
      end
      flash_port_pkg::OP_READ:
        stateNext = flash_port_pkg::OP_IDLE;
      flash_port_pkg::OP_WRITE:
        stateNext = flash_port_pkg::OP_WAIT;
      flash_port_pkg::OP_WAIT:
      begin
        if (rcTickEdge)
        begin
          tickCountNext = tickCountReg + 16'h0001;
          if (tickCountNext >= tickLimitReg)
            stateNext = flash_port_pkg::OP_IDLE;
        end
      end
      default:
        stateNext = flash_port_pkg::OP_IDLE;
    endcase
    stallNext = (stateNext != flash_port_pkg::OP_IDLE);
    // Under an external clock the oscillator runs only while self-programming is enabled
    oscNext   = enableNext | ~pinSync[1];
  end

  // Read data; the trigger register always reads as zero, unmapped offsets read zero
  always_comb
  begin
    rdDataNext = rdDataReg;
    if (sfrReq.rdEn)
    begin
      if (sfrReq.addr == `OFS_ADDR_LOW)
        rdDataNext = addrLowReg;
      else if (sfrReq.addr == `OFS_ADDR_HIGH)
        rdDataNext = addrHighReg;
      else if (sfrReq.addr == `OFS_DATA_BYTE)
        rdDataNext = dataByteReg;
      else if (sfrReq.addr == `OFS_COMMAND)
        rdDataNext = commandReg;
      else if (sfrReq.addr == `OFS_UPDATE_PERMISSION)
        rdDataNext = updPermReg;
      else if (sfrReq.addr == `OFS_CHIP_CONTROL)
        rdDataNext = {1'b0, faultReg, 4'h0, bootSelReg, enableReg};
      else
        rdDataNext = `RST_BYTE_ZERO;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addrLowReg   <= `RST_BYTE_ZERO;
      addrHighReg  <= `RST_BYTE_ZERO;
      dataByteReg  <= `RST_BYTE_ZERO;
      commandReg   <= `RST_COMMAND;
      updPermReg   <= `RST_BYTE_ZERO;
      enableReg    <= 1'b0;
      bootSelReg   <= 1'b0;
      faultReg     <= 1'b0;
      rdDataReg    <= `RST_BYTE_ZERO;
      stateReg     <= flash_port_pkg::OP_IDLE;
      tickCountReg <= 16'h0000;
      tickLimitReg <= 16'h0000;
      stallReg     <= 1'b0;
      oscReg       <= 1'b1;
    end
    else
    begin
      addrLowReg   <= addrLowNext;
      addrHighReg  <= addrHighNext;
      dataByteReg  <= dataByteNext;
      commandReg   <= commandNext;
      updPermReg   <= updPermNext;
      enableReg    <= enableNext;
      bootSelReg   <= bootSelNext;
      faultReg     <= faultNext;
      rdDataReg    <= rdDataNext;
      stateReg     <= stateNext;
      tickCountReg <= tickCountNext;
      tickLimitReg <= tickLimitNext;
      stallReg     <= stallNext;
      oscReg       <= oscNext;
    end
  end

  assign sfrRdData   = rdDataReg;
  assign cpuStall    = stallReg;
  assign rcOscEnable = oscReg;

  sequence seqUnlockedGo;
    goWrite && !goFault;
  endsequence

  sequence seqReadDone;
    (stateReg == flash_port_pkg::OP_READ) ##1 (stateReg == flash_port_pkg::OP_IDLE);
  endsequence

  AST_TRIGGER_READS_ZERO: assert property (@(posedge clk) disable iff (rst)
    (sfrReq.rdEn && sfrReq.addr == `OFS_TRIGGER) |=> (sfrRdData == 8'h00))
    else $error("Trigger register read back nonzero");

  AST_LOCKED_GO_IGNORED: assert property (@(posedge clk) disable iff (rst)
    (sfrReq.wrEn && sfrReq.addr == `OFS_TRIGGER && !unlocked && !cpuStall) |=> !cpuStall)
    else $error("Trigger accepted without unlock pair");

  AST_DISABLED_GO_IGNORED: assert property (@(posedge clk) disable iff (rst)
    (sfrReq.wrEn && sfrReq.addr == `OFS_TRIGGER && !enableReg && !cpuStall) |=> !cpuStall)
    else $error("Trigger accepted with self-program disabled");

  AST_GO_STALLS: assert property (@(posedge clk) disable iff (rst)
    seqUnlockedGo |=> cpuStall)
    else $error("Accepted trigger did not stall the core");

  AST_READ_RELEASE: assert property (@(posedge clk) disable iff (rst)
    (seqUnlockedGo and isReadCmd) |=> cpuStall ##[1:READ_RELEASE_MAX] !cpuStall)
    else $error("Read operation did not release the stall");

  AST_READ_DATA_LEFT: assert property (@(posedge clk) disable iff (rst)
    seqReadDone |-> (dataByteReg == $past(flashPortData, 1)))
    else $error("Read byte not left in data register");

  AST_FAULT_ON_BAD_GO: assert property (@(posedge clk) disable iff (rst)
    (goWrite && goFault) |=> (faultReg && !cpuStall))
    else $error("Faulty trigger did not set the fault flag");

  AST_NO_UPDATE_REFUSED: assert property (@(posedge clk) disable iff (rst)
    (goWrite && isProgramCmd && !updPermReg[`BIT_APP_UPDATE]) |=> !cpuStall ##1 !programEn)
    else $error("Program ran without update permission");

  AST_ENABLE_LOCKED: assert property (@(posedge clk) disable iff (rst)
    (sfrReq.wrEn && sfrReq.addr == `OFS_CHIP_CONTROL && !unlocked) |=> $stable(enableReg))
    else $error("Enable changed without unlock pair");

  AST_OSC_WITH_ENABLE: assert property (@(posedge clk) disable iff (rst)
    enableReg |-> rcOscEnable)
    else $error("Oscillator off while self-program enabled");

  AST_LOCK_NO_EFFECT: assert property (@(posedge clk) disable iff (rst)
    (seqUnlockedGo and securityLock) |=> cpuStall)
    else $error("Security lock blocked an operation");

  AST_ADDR_LOW_STORED: assert property (@(posedge clk) disable iff (rst)
    (sfrReq.wrEn && sfrReq.addr == `OFS_ADDR_LOW) ##1 !sfrReq.wrEn ##1 (sfrReq.rdEn
      && sfrReq.addr == `OFS_ADDR_LOW && !sfrReq.wrEn) |=> (sfrRdData == $past(sfrReq.wrData, 3)))
    else $error("Low address byte not read back");
endmodule : in_app_flash_update_port

// >>> test/rc_osc_model.sv
// Behavioural internal RC oscillator feeding the port's tick input
`timescale 1ns/1ps
module rc_osc_model (
  input  wire logic enable,
  output logic      tick
);
  // Odd half period keeps the ticks unrelated in phase to the system clock
  initial tick = 1'b0;
  always
  begin
    #19.7;
    // Held low while disabled, so no stray edge can reach the duration counter
    tick = enable ? ~tick : 1'b0;
  end
endmodule : rc_osc_model

// >>> test/testbench.sv
// Self-checking bench for the in-application flash update port
`timescale 1ns/1ps
`include "flash_port_defines.svh"
module testbench;
  logic                     clk;
  logic                     rst;
  flash_port_pkg::sfr_req_t sfrReq;
  logic [7:0]               sfrRdData;
  logic                     cpuStall;
  logic                     rcOscEnable;
  logic                     extClkSelect;
  logic                     rcTick;
  logic                     brownOutInhibit;
  logic                     securityLock;
  logic [`FLASH_ADDR_W-1:0] codeAddr;
  logic [7:0]               codeData;
  int                       mismatches;
  int                       comparisons;
  int                       flashModel [int];
  logic [7:0]               v;
  int                       cyc;
  int                       i;
  int                       a;
  logic [7:0]               ofs   [5] = '{8'hA6, 8'hA7, 8'hAE, 8'hA4, 8'hAF};
  logic [7:0]               rstv  [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h30};
  logic [7:0]               badC  [3] = '{8'h55, 8'h21, 8'h22};
  logic [15:0]              badA  [3] = '{16'h0200, 16'h4000, 16'h0200};
  int                       vis   [5] = '{'h1FF, 'h200, 'h27F, 'h280, 0};

  in_app_flash_update_port DUT (.clk(clk), .rst(rst), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
    .cpuStall(cpuStall), .rcOscEnable(rcOscEnable), .extClkSelect(extClkSelect), .rcTick(rcTick),
    .brownOutInhibit(brownOutInhibit), .securityLock(securityLock), .codeAddr(codeAddr),
    .codeData(codeData));
  rc_osc_model osc (.enable(rcOscEnable), .tick(rcTick));

  initial clk = 1'b0;
  always #4 clk = ~clk;

  task automatic tally_and_finish;
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [7:0] expv, input logic [7:0] act);
    comparisons++;
    if (expv !== act)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, expv, act);
    end
  endtask : check

  // One idle cycle between writes keeps each strobe a clean single pulse
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    sfrReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: ad, wrData: d};
    @(posedge clk);
    sfrReq.wrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge clk);
    sfrReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: ad, wrData: 8'h00};
    @(posedge clk);
    sfrReq.rdEn <= 1'b0;
    @(negedge clk);
    d = sfrRdData;
  endtask : rd

  task automatic pwr(input logic [7:0] ad, input logic [7:0] d);
    wr(`OFS_TIMED_ACCESS, `TA_FIRST);
    wr(`OFS_TIMED_ACCESS, `TA_SECOND);
    wr(ad, d);
  endtask : pwr

  // Looks for the stall, then waits a bounded time for its release
  task automatic watch(input bit expectRun, output int n);
    bit seen;
    seen = 1'b0;
    for (n = 0; n < 4; n++)
    begin
      @(negedge clk);
      if (cpuStall === 1'b1)
        seen = 1'b1;
    end
    check({7'h00, expectRun}, {7'h00, seen});
    for (n = 0; n < 3000 && cpuStall !== 1'b0; n++)
      @(negedge clk);
    if (n == 3000)
    begin
      check(8'h00, 8'h01);
      tally_and_finish();
    end
  endtask : watch

  task automatic op(input logic [7:0] cmd, input logic [15:0] ad, input logic [7:0] d, input bit run);
    wr(`OFS_COMMAND, cmd);
    wr(`OFS_ADDR_HIGH, ad[15:8]);
    wr(`OFS_ADDR_LOW, ad[7:0]);
    wr(`OFS_DATA_BYTE, d);
    pwr(`OFS_TRIGGER, 8'h01);
    watch(run, cyc);
  endtask : op

  task automatic code_rd(input int ad, output logic [7:0] d);
    @(posedge clk);
    codeAddr <= ad[`FLASH_ADDR_W-1:0];
    @(posedge clk);
    @(negedge clk);
    d = codeData;
  endtask : code_rd

  initial
  begin
    sfrReq = '0;
    rst = 1'b1;
    extClkSelect = 1'b0;
    brownOutInhibit = 1'b0;
    securityLock = 1'b0;
    codeAddr = '0;
    mismatches = 0;
    comparisons = 0;
    v = 8'($urandom(32'hd262f1d7));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(8'h00, {7'h00, cpuStall});
    check(8'h01, {7'h00, rcOscEnable});
    for (i = 0; i < 5; i++)
    begin
      rd(ofs[i], v);
      check(rstv[i], v);
    end
    for (i = 0; i < 3; i++)
    begin
      a = $urandom;
      wr(ofs[i], 8'(a));
      rd(ofs[i], v);
      check(8'(a), v);
    end
    wr(`OFS_CHIP_CONTROL, 8'h01);
    rd(`OFS_CHIP_CONTROL, v);
    check(8'h00, v & 8'h01);
    op(`CMD_BYTE_READ_AP, 16'h0000, 8'h00, 1'b0);
    pwr(`OFS_CHIP_CONTROL, 8'h03);
    rd(`OFS_CHIP_CONTROL, v);
    check(8'h03, v & 8'h03);
    check(8'h01, {7'h00, rcOscEnable});
    wr(`OFS_TRIGGER, 8'h01);
    watch(1'b0, cyc);
    wr(`OFS_TIMED_ACCESS, `TA_FIRST);
    wr(`OFS_TIMED_ACCESS, `TA_SECOND);
    wr(`OFS_ADDR_LOW, 8'h00);
    wr(`OFS_TRIGGER, 8'h01);
    watch(1'b0, cyc);
    op(`CMD_BYTE_PROGRAM_AP, 16'h0200, 8'h5A, 1'b0);
    rd(`OFS_CHIP_CONTROL, v);
    check(8'h41, v & 8'h41);
    pwr(`OFS_CHIP_CONTROL, 8'h01);
    rd(`OFS_CHIP_CONTROL, v);
    check(8'h01, v & 8'h41);
    pwr(`OFS_UPDATE_PERMISSION, 8'h01);
    securityLock <= 1'b1;
    vis[4] = 'h200 + ($urandom % `PAGE_BYTES);
    for (i = 0; i < 5; i++)
    begin
      a = $urandom;
      op(`CMD_BYTE_PROGRAM_AP, 16'(vis[i]), 8'(a), 1'b1);
      flashModel[vis[i]] = a & 'hFF;
    end
    op(`CMD_PAGE_ERASE_AP, 16'h0200, 8'hFF, 1'b1);
    // RC model ticks every 39.4 ns, so compare in tenths of a ns; sync adds a few clocks
    check(8'h01, {7'h00, (cyc + 3) * 80 >= (`ERASE_TICKS - 1) * 394});
    check(8'h01, {7'h00, (cyc + 3) * 80 <= (`ERASE_TICKS + 2) * 394});
    for (a = 'h200; a < 'h280; a++)
      flashModel[a] = 'hFF;
    for (i = 0; i < 5; i++)
    begin
      code_rd(vis[i], v);
      check(8'(flashModel[vis[i]]), v);
      op(`CMD_BYTE_READ_AP, 16'(vis[i]), 8'h00, 1'b1);
      check(8'h00, {7'h00, cpuStall});
      rd(`OFS_DATA_BYTE, v);
      check(8'(flashModel[vis[i]]), v);
    end
    for (i = 0; i < 3; i++)
    begin
      brownOutInhibit <= (i == 2);
      repeat (4) @(posedge clk);
      op(badC[i], badA[i], 8'h00, 1'b0);
      rd(`OFS_CHIP_CONTROL, v);
      check(8'h41, v & 8'h41);
      pwr(`OFS_CHIP_CONTROL, 8'h01);
    end
    extClkSelect <= 1'b1;
    pwr(`OFS_CHIP_CONTROL, 8'h00);
    repeat (6) @(negedge clk);
    check(8'h00, {7'h00, rcOscEnable});
    op(`CMD_BYTE_READ_AP, 16'h0200, 8'h00, 1'b0);
    tally_and_finish();
  end
endmodule : testbench
